// ==== rtl/irm_defs.svh ====
// Purpose: offsets, field positions and other constants of the rx match filter
// Assumes: included by the filter design file by bare name
// Notes:   definitions only
`ifndef IRM_DEFS_SVH
`define IRM_DEFS_SVH
`define IRM_PTR_BASE      16'h040c
`define IRM_MATCH_BASE    16'h410c
`define IRM_CTX_STRIDE    16'h0020
`define IRM_CTRL_BASE     16'h0400
`define IRM_STAT_BASE     16'h0404
`define IRM_MASK_HI       16'h0478
`define IRM_MASK_LO       16'h047c
`define IRM_NUM_CTX       8
`define IRM_TAG_TOP       31
`define IRM_CYC_HI        26
`define IRM_CYC_LO        12
`define IRM_SYNC_HI       11
`define IRM_SYNC_LO       8
`define IRM_SYNC_GATE     6
`define IRM_CHAN_HI       5
`define IRM_MATCH_WMASK   32'hf7ff_ff7f
`define IRM_RUN_BIT       15
`define IRM_SOC_BIT       29
`define IRM_MULTI_BIT     28
`define IRM_ACTIVE_BIT    10
`define IRM_WAIT_SYNC     2'h3
`define IRM_TAG_ONE       2'h1
`define IRM_ZERO32        32'h0000_0000
`endif

// ==== rtl/irm_filter.sv ====
// Summary of operation
// - setting run makes the context fetch from its descriptor pointer.
// - eight contexts; pointer at base 40Ch plus 32 times context number.
// - pointer bits 31:4 hold the 16-byte-aligned descriptor address.
// - tag accept bits 31..28 enable tags 11b down to 00b.
// - match register bits 27 and 7 always read zero.
// - start-on-cycle waits until start cycle equals the cycle timer.
// - compare uses two low seconds bits and the 13-bit cycle count.
// - sync value compared with packet sync when descriptor wait is 11b.
// - gated tag 01b packets need upper sync bits 00b.
// - other tags, or gate clear, use tag accept bits alone.
// - while gate lock is set the gate bit is read-only one.
// - six-bit channel field selects the single accepted channel.
// - multi-channel mode uses the shared channel mask instead.
// - start-on-cycle enable clears once the context becomes active.
//
// Purpose: isochronous receive start pointer, start cycle and packet filter
// Assumes: cycle timer and packets come from logic on i_clk_sys
// Notes:   control bits live in a local register at IRM_CTRL_BASE + 32*n
//          only one context at a time should run in multi-channel mode
//          contexts started in the same cycle share one fetch address
//          the cycle timer is expected on the same clock, unsynchronised
`timescale 1ns/100ps
`include "irm_defs.svh"
module irm_filter
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset,
    input  wire logic [15:0]       i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [31:0]            o_rdata,
    input  wire logic [31:0]       i_cycle_timer,
    input  wire logic              i_sync_gate_lock,
    input  wire logic [15:0]       i_wait_sync,
    input  wire logic              i_pkt_valid,
    input  wire irm_pkg::irm_pkt_s i_pkt,
    output logic                   o_pkt_ready,
    output logic                   o_res_valid,
    output irm_pkg::irm_res_s      o_res,
    input  wire logic              i_res_ready,
    output logic [7:0]             o_fetch,
    output logic [27:0]            o_fetch_addr,
    output logic [7:0]             o_ctx_active
);
    import irm_pkg::*;

    // context count is fixed; the decode below relies on it
    localparam int NCTX = `IRM_NUM_CTX;

    // idle until run, optional wait for the start cycle, then receive
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACTIVE} irm_ctx_e;

    // every flop of the block outside the result buffer, registered by one process
    typedef struct packed {
        irm_ptr_s   [NCTX-1:0] ptr;
        irm_match_s [NCTX-1:0] match;
        irm_ctl_s   [NCTX-1:0] ctl;
        irm_ctx_e   [NCTX-1:0] fsm;
        logic       [31:0]     mask_hi;
        logic       [31:0]     mask_lo;
        logic       [31:0]     rdata;
        logic       [7:0]      fetch;
        logic       [27:0]     fetch_addr;
        logic                  res_valid;
        irm_res_s              res;
    } irm_state_s;

    // current and next state of the block outside the result buffer
    irm_state_s st_q;
    irm_state_s st_d;
    logic       buf_ready;
    logic       buf_valid;
    irm_res_s   buf_data;
    logic [7:0] acc;
    logic [14:0] now_cycle;

    // per-context strobes from the address decode and the start cycle compare
    logic [NCTX-1:0] ptr_wr;
    logic [NCTX-1:0] match_wr;
    logic [NCTX-1:0] ctl_wr;
    logic [NCTX-1:0] ptr_rd;
    logic [NCTX-1:0] match_rd;
    logic [NCTX-1:0] ctl_rd;
    logic [NCTX-1:0] cyc_hit;

    ////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // per-context offset hit; stride of 32 bytes
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] base,
                                 input int          n);
        return a == (base + 16'(n * 32));
    endfunction

    // view of the match register as software reads it
    function automatic logic [31:0] match_word(input irm_match_s m,
                                               input logic       lock);
        logic [31:0] w;
        w = `IRM_ZERO32;
        w[31:28] = m.accept_tags;
        w[26:12] = m.start_cycle_value;
        w[11:8]  = m.sync_value;
        w[6]     = m.tag_one_sync_gate | lock;
        w[5:0]   = m.channel_select;
        return w;   // bits 27 and 7 stay zero
    endfunction

    // bit of the 64-channel shared mask
    function automatic logic mask_bit(input logic [31:0] hi,
                                      input logic [31:0] lo,
                                      input logic [5:0]  ch);
        logic [63:0] m;
        m = {hi, lo};
        return m[ch];
    endfunction

    // packs a written word into the match fields;
    // reserved bits 27 and 7 are dropped here
    function automatic irm_match_s match_from_word(input logic [31:0] w);
        irm_match_s m;
        m.accept_tags       = w[`IRM_TAG_TOP -: 4];
        m.start_cycle_value = w[`IRM_CYC_HI:`IRM_CYC_LO];
        m.sync_value        = w[`IRM_SYNC_HI:`IRM_SYNC_LO];
        m.tag_one_sync_gate = w[`IRM_SYNC_GATE];
        m.channel_select    = w[`IRM_CHAN_HI:0];
        return m;
    endfunction

    // control word as software reads it;
    // bits without a flop read back zero
    function automatic logic [31:0] ctl_word(input irm_ctl_s c);
        logic [31:0] w;
        w = `IRM_ZERO32;
        w[`IRM_RUN_BIT]    = c.run;
        w[`IRM_SOC_BIT]    = c.start_on_cycle_enable;
        w[`IRM_MULTI_BIT]  = c.multi_channel_select_mode;
        w[`IRM_ACTIVE_BIT] = c.active;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // two low seconds bits beside the full 13-bit cycle count; the higher
    // seconds bits are left out, so a start value recurs every 4 seconds
    assign now_cycle = {i_cycle_timer[26:25],   // low seconds bits
                        i_cycle_timer[24:12]};  // cycle count

    ////////////////////////////////////////////////////////////////////////
    // per-context register decode, shared by the write and read paths
    generate
        for (genvar g = 0; g < NCTX; g++)
        begin : g_dec
            // each context's pointer, match and control words sit 32 bytes past those of the context before
            assign ptr_wr[g]   = i_wr && hit(i_addr, `IRM_PTR_BASE, g);
            assign match_wr[g] = i_wr && hit(i_addr, `IRM_MATCH_BASE, g);
            assign ctl_wr[g]   = i_wr && hit(i_addr, `IRM_CTRL_BASE, g);
            assign ptr_rd[g]   = i_rd && hit(i_addr, `IRM_PTR_BASE, g);
            assign match_rd[g] = i_rd && hit(i_addr, `IRM_MATCH_BASE, g);
            assign ctl_rd[g]   = i_rd && hit(i_addr, `IRM_CTRL_BASE, g);
            // start cycle compare, one comparator per context
            assign cyc_hit[g] =
                (now_cycle == st_q.match[g].start_cycle_value);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // per-context acceptance, all checks combined
    generate
        for (genvar g = 0; g < NCTX; g++)
        begin : g_acc
            logic chan_ok;
            logic tag_ok;
            logic sync_ok;
            logic gate;
            irm_match_s m;
            // this context's match word and its effective gate
            assign m = st_q.match[g];
            assign gate = m.tag_one_sync_gate | i_sync_gate_lock;
            // mask replaces the channel field in multi mode
            assign chan_ok = st_q.ctl[g].multi_channel_select_mode ?
                mask_bit(st_q.mask_hi, st_q.mask_lo, i_pkt.channel) :
                (i_pkt.channel == m.channel_select);
            assign tag_ok = m.accept_tags[i_pkt.tag];
            // gated tag one needs upper sync bits 00b; others unaffected
            assign sync_ok =
                ((i_pkt.tag == `IRM_TAG_ONE) && gate) ?
                    (i_pkt.sync[3:2] == 2'h0) : 1'b1;
            // wait-on-sync descriptors only take the matching sync value;
            // idle and waiting contexts drop every packet
            assign acc[g] = (st_q.fsm[g] == ST_ACTIVE) && chan_ok &&
                tag_ok && sync_ok &&
                (i_wait_sync[2*g +: 2] != `IRM_WAIT_SYNC ||
                 i_pkt.sync == m.sync_value);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // register file, context sequencing and packet capture
    always_comb
    begin
        st_d = st_q;
        // pulses and read data fall back to zero unless refreshed
        st_d.fetch = 8'h00;
        st_d.rdata = `IRM_ZERO32;
        // the stage empties into the buffer whenever the buffer has room
        if (buf_ready)
            st_d.res_valid = 1'b0;
        // shared channel mask, one word per half
        if (i_wr)
        begin
            if (i_addr == `IRM_MASK_HI)
                st_d.mask_hi = i_wdata;
            if (i_addr == `IRM_MASK_LO)
                st_d.mask_lo = i_wdata;
        end
        if (i_rd)
        begin
            if (i_addr == `IRM_MASK_HI)
                st_d.rdata = st_q.mask_hi;
            if (i_addr == `IRM_MASK_LO)
                st_d.rdata = st_q.mask_lo;
        end
        // per-context register writes, reads and sequencing
        for (int n = 0; n < NCTX; n++)
        begin
            // whole pointer word is kept; the fetch uses bits 31:4
            if (ptr_wr[n])
                st_d.ptr[n] = i_wdata;
            if (match_wr[n])
            begin
                st_d.match[n] = match_from_word(i_wdata);
                // a locked gate bit ignores the write and keeps its value
                if (i_sync_gate_lock)
                    st_d.match[n].tag_one_sync_gate =
                        st_q.match[n].tag_one_sync_gate;
            end
            // active is status only and is never written
            if (ctl_wr[n])
            begin
                st_d.ctl[n].run = i_wdata[`IRM_RUN_BIT];
                st_d.ctl[n].start_on_cycle_enable = i_wdata[`IRM_SOC_BIT];
                st_d.ctl[n].multi_channel_select_mode =
                    i_wdata[`IRM_MULTI_BIT];
            end
            // read mux; a read hits at most one word
            if (ptr_rd[n])
                st_d.rdata = st_q.ptr[n];
            if (match_rd[n])
                st_d.rdata = match_word(st_q.match[n], i_sync_gate_lock);
            if (ctl_rd[n])
                st_d.rdata = ctl_word(st_q.ctl[n]);
            // context sequencing; run low always returns to idle
            case (st_q.fsm[n])
                // start: fetch pulse and pointer leave together
                ST_IDLE:
                begin
                    if (st_q.ctl[n].run)
                    begin
                        st_d.fetch[n] = 1'b1;
                        st_d.fetch_addr =
                            st_q.ptr[n].descriptor_block_pointer;
                        st_d.fsm[n] = st_q.ctl[n].start_on_cycle_enable ?
                            ST_WAIT : ST_ACTIVE;
                    end
                end
                // the enable drops as the context goes active
                ST_WAIT:
                begin
                    if (!st_q.ctl[n].run)
                        st_d.fsm[n] = ST_IDLE;
                    else if (cyc_hit[n])
                    begin
                        st_d.fsm[n] = ST_ACTIVE;
                        st_d.ctl[n].start_on_cycle_enable = 1'b0;
                    end
                end
                // stays until software clears run
                ST_ACTIVE:
                begin
                    if (!st_q.ctl[n].run)
                        st_d.fsm[n] = ST_IDLE;
                end
                default:
                    st_d.fsm[n] = ST_IDLE;
            endcase
            st_d.ctl[n].active = (st_d.fsm[n] == ST_ACTIVE);
        end
        // accepted packets wait in the result stage until the buffer frees;
        // every packet yields one result, even with no context accepting
        if (i_pkt_valid && (!st_q.res_valid || buf_ready))
        begin
            st_d.res_valid = 1'b1;
            st_d.res.pkt = i_pkt;
            st_d.res.accept = acc;
        end
    end

    // one register for all state outside the result buffer; reset clears every context
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // result buffer; its stall reaches the packet source via o_pkt_ready
    // the buffer's ready doubles as the stage's drain condition
    irm_skid u_skid
    (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_valid   (st_q.res_valid),
        .i_data    (st_q.res),
        .o_ready   (buf_ready),
        .o_valid   (buf_valid),
        .o_data    (buf_data),
        .i_ready   (i_res_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs; result from buffer flops, ready from stage and buffer flops, via small logic
    assign o_rdata      = st_q.rdata;
    assign o_fetch      = st_q.fetch;
    assign o_fetch_addr = st_q.fetch_addr;
    assign o_res_valid  = buf_valid;
    assign o_res        = buf_data;
    assign o_pkt_ready  = !st_q.res_valid || buf_ready;
    // active bit of each context, straight from its flop
    generate
        for (genvar k = 0; k < NCTX; k++)
        begin : g_act
            assign o_ctx_active[k] = st_q.ctl[k].active;
        end
    endgenerate
endmodule

// ==== rtl/irm_pkg.sv ====
// Purpose: types shared by the rx match filter files
// Assumes: field widths are written out here, not taken from irm_defs.svh
// Notes:   packets travel as irm_pkt_s
package irm_pkg;
    typedef struct packed {
        logic [1:0] tag;
        logic [5:0] channel;
        logic [3:0] sync;
    } irm_pkt_s;

    typedef struct packed {
        irm_pkt_s   pkt;
        logic [7:0] accept;
    } irm_res_s;

    typedef struct packed {
        logic [27:0] descriptor_block_pointer;
        logic [3:0]  contig_count;
    } irm_ptr_s;

    typedef struct packed {
        logic [3:0]  accept_tags;
        logic [14:0] start_cycle_value;
        logic [3:0]  sync_value;
        logic        tag_one_sync_gate;
        logic [5:0]  channel_select;
    } irm_match_s;

    typedef struct packed {
        logic run;
        logic start_on_cycle_enable;
        logic multi_channel_select_mode;
        logic active;
    } irm_ctl_s;
endpackage

// ==== rtl/irm_skid.sv ====
// Purpose: two-entry buffer for filter results
// Assumes: one clock, synchronous active-high reset
// Notes:   a receiver stall loses no word; ready drops only when full
`timescale 1ns/100ps
module irm_skid
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset,
    input  wire logic              i_valid,
    input  wire irm_pkg::irm_res_s i_data,
    output logic                   o_ready,
    output logic                   o_valid,
    output irm_pkg::irm_res_s      o_data,
    input  wire logic              i_ready
);
    import irm_pkg::*;

    typedef struct packed {
        irm_res_s [1:0] mem;
        logic           wp;
        logic           rp;
        logic [1:0]     cnt;
    } irm_skid_s;

    irm_skid_s st_q;
    irm_skid_s st_d;
    logic      push;
    logic      pop;

    // pointer bookkeeping; count bounds give honest full and empty
    always_comb
    begin
        st_d = st_q;
        push = i_valid && (st_q.cnt != 2'h2);
        pop  = i_ready && (st_q.cnt != 2'h0);
        if (push)
        begin
            st_d.mem[st_q.wp] = i_data;
            st_d.wp = ~st_q.wp;
        end
        if (pop)
            st_d.rp = ~st_q.rp;
        if (push && !pop)
            st_d.cnt = st_q.cnt + 2'h1;
        else if (pop && !push)
            st_d.cnt = st_q.cnt - 2'h1;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign o_ready = (st_q.cnt != 2'h2);
    assign o_valid = (st_q.cnt != 2'h0);
    assign o_data  = st_q.mem[st_q.rp];
endmodule

// ==== verification/irm_filter_sva.sv ====
// Purpose: port checks for irm_filter
// Assumes: one clock, sync active-high reset
// Notes:   bound at the foot of this file
`timescale 1ns/100ps
module irm_filter_sva
(
    input wire logic              i_clk_sys,
    input wire logic              i_reset,
    input wire logic [15:0]       i_addr,
    input wire logic [31:0]       i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [31:0]       o_rdata,
    input wire logic              i_sync_gate_lock,
    input wire logic              i_pkt_valid,
    input wire logic              o_pkt_ready,
    input wire logic              o_res_valid,
    input wire irm_pkg::irm_res_s o_res,
    input wire logic              i_res_ready,
    input wire logic [7:0]        o_fetch,
    input wire logic [7:0]        o_ctx_active
);
    import irm_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////
    // read of any match register
    logic m_rd;
    assign m_rd = i_rd && i_addr[15:8] == 8'h41 && i_addr[4:0] == 5'h0c;
    property p_fetch_cause;
        o_fetch != 8'h00 |-> $past(i_wr, 2) && $past(i_wdata[15], 2)
            && $past(i_addr[4:0], 2) == 5'h00;
    endproperty
    a_fetch_cause: assert property (p_fetch_cause)
        else $error("fetch without a run write");
    property p_fetch_once;
        o_fetch != 8'h00 |=> (o_fetch & $past(o_fetch)) == 8'h00;
    endproperty
    a_fetch_once: assert property (p_fetch_once)
        else $error("fetch pulse longer than one cycle");
    property p_rsv;
        $past(m_rd) |-> o_rdata[27] == 1'b0 && o_rdata[7] == 1'b0;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved match bit read as one");
    property p_lock;
        $past(m_rd) && $past(i_sync_gate_lock) |-> o_rdata[6];
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked gate bit read as zero");
    property p_rd_idle;
        !$past(i_rd) |-> o_rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its cycle");
    property p_hold;
        o_res_valid && !i_res_ready |=> o_res_valid && $stable(o_res);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stalled result changed");
    property p_refuse;
        !o_pkt_ready |-> o_res_valid;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("packet refused with empty buffer");
    property p_latency;
        $rose(o_res_valid) |-> $past(i_pkt_valid && o_pkt_ready, 2);
    endproperty
    a_latency: assert property (p_latency)
        else $error("result without a packet two cycles back");
    property p_act_fall;
        ($past(o_ctx_active) & ~o_ctx_active) != 8'h00
            |-> $past(i_wr) || $past(i_wr, 2);
    endproperty
    a_act_fall: assert property (p_act_fall)
        else $error("context went inactive on its own");
    c_fetch: cover property (o_fetch != 8'h00);
    c_stall: cover property (o_res_valid && !i_res_ready);
    c_lock: cover property ($past(m_rd) && $past(i_sync_gate_lock));
endmodule
bind irm_filter irm_filter_sva u_sva (.*);

// ==== verification/irm_pkt_src.sv ====
// Purpose: packet source standing for the serial bus link
// Assumes: packets handed over by send, one at a time
// Notes:   idle lines show the inverse of the last packet
`timescale 1ns/100ps
module irm_pkt_src
(
    input  wire logic         i_clk_sys,
    input  wire logic         i_pkt_ready,
    output logic              o_pkt_valid,
    output irm_pkg::irm_pkt_s o_pkt
);
    import irm_pkg::*;
    initial
    begin
        o_pkt_valid = 1'b0;
        o_pkt = 12'h000;
    end
    // hold the packet until the filter takes it
    task automatic send(irm_pkt_s p);
        @(posedge i_clk_sys);
        o_pkt_valid <= 1'b1;
        o_pkt <= p;
        do
            @(negedge i_clk_sys);
        while (i_pkt_ready !== 1'b1);
        @(posedge i_clk_sys);
        o_pkt_valid <= 1'b0;
        o_pkt <= ~p;
    endtask
endmodule

// ==== verification/iso_rx_context_match_filter_tb_top.sv ====
// Purpose: self-checking bench for irm_filter
// Assumes: irm_pkt_src feeds packets
// Notes:   expected words queued, monitors compare
`timescale 1ns/100ps
module iso_rx_context_match_filter_tb_top;
    import irm_pkg::*;
    logic        i_clk_sys = 1'b0;
    logic        i_reset = 1'b1;
    logic [15:0] i_addr = 16'h0000;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [31:0] i_cycle_timer = 32'h0000_0000;
    logic        i_sync_gate_lock = 1'b0;
    logic [15:0] i_wait_sync = 16'h0000;
    logic        i_res_ready = 1'b0;
    logic        i_pkt_valid, o_pkt_ready, o_res_valid, rd_ph = 1'b0;
    irm_pkt_s    i_pkt, k;
    irm_res_s    o_res, res_q [$];
    logic [31:0] o_rdata, p, mt [8], rd_q [$];
    logic [7:0]  o_fetch, o_ctx_active;
    logic [27:0] o_fetch_addr;
    logic [35:0] fq [$];
    logic [63:0] mask;
    logic [14:0] cyc;
    int          failures = 0, tests_run = 0, seed = 32'h046dcbe7;
    irm_filter u_dut (.*);
    irm_pkt_src u_src (.i_clk_sys(i_clk_sys), .i_pkt_ready(o_pkt_ready),
                       .o_pkt_valid(i_pkt_valid), .o_pkt(i_pkt));
    always #50 i_clk_sys = ~i_clk_sys;
    ////////////////////////////////////////
    task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(logic [15:0] a, logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(logic [15:0] a, logic [31:0] e);
        rd_q.push_back(e);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
    endtask
    // own model of the accept vector; context 6 runs on the mask
    function automatic logic [7:0] acc(irm_pkt_s q);
        logic [7:0]  a;
        logic [31:0] m;
        for (int n = 0; n < 8; n++)
        begin
            m = mt[n];
            a[n] = (n == 6 ? mask[q.channel] : m[5:0] == q.channel)
                && m[28 + q.tag]
                && !(q.tag == 2'h1 && (m[6] | i_sync_gate_lock)
                     && q.sync[3:2] != 2'h0)
                && !(i_wait_sync[2*n +: 2] == 2'h3 && q.sync != m[11:8]);
        end
        return a;
    endfunction
    // sampled mid-cycle, clear of the edge updates
    always @(posedge i_clk_sys)
        rd_ph <= i_rd;
    always @(negedge i_clk_sys)
    begin
        if (rd_ph)
            check("rdata", o_rdata, rd_q.pop_front());
        if (o_fetch !== 8'h00)
            check("fetch", {o_fetch, o_fetch_addr}, fq.pop_front());
        if ((o_res_valid & i_res_ready) === 1'b1)
            check("result", o_res, res_q.pop_front());
    end
    initial
    begin
        repeat (4) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        for (int n = 0; n < 8; n++)
        begin
            p = $random(seed) & 32'hffff_fff0 | 32'h0000_0001;
            wr(16'h040c + 16'(32 * n), p);
            rd(16'h040c + 16'(32 * n), p);
            fq.push_back({8'h01 << n, p[31:4]});
            wr(16'h0400 + 16'(32 * n), n == 6 ? 32'h1000_8000 : 32'h0000_8000);
            repeat (3) @(posedge i_clk_sys);
        end
        @(negedge i_clk_sys);
        check("active", o_ctx_active, 8'hff);
        $display("test start done");
        mask = {$random(seed), $random(seed)};
        wr(16'h0478, mask[63:32]);
        wr(16'h047c, mask[31:0]);
        for (int n = 0; n < 8; n++)
        begin
            mt[n] = $random(seed);
            wr(16'h410c + 16'(32 * n), mt[n]);
            mt[n] &= 32'hf7ff_ff7f;
            rd(16'h410c + 16'(32 * n), mt[n]);
        end
        i_sync_gate_lock <= 1'b1;
        wr(16'h410c, mt[0] & 32'hffff_ffbf);
        rd(16'h410c, mt[0] | 32'h0000_0040);
        $display("test registers done");
        // stall first so the buffer fills and refuses, then drain
        for (int r = 0; r < 2; r++)
        begin
            i_sync_gate_lock <= 1'(r);
            i_wait_sync <= 16'($random(seed));
            i_res_ready <= 1'b0;
            @(posedge i_clk_sys);
            fork
                for (int j = 0; j < 30; j++)
                begin
                    k = 12'($random(seed));
                    if (k.tag[0])
                        k.channel = mt[k.sync[2:0]][5:0];
                    res_q.push_back({k, acc(k)});
                    u_src.send(k);
                end
            join_none
            repeat (20) @(posedge i_clk_sys);
            @(negedge i_clk_sys);
            check("pkt_ready", o_pkt_ready, 1'b0);
            while (res_q.size() != 0)
            begin
                @(posedge i_clk_sys);
                i_res_ready <= 1'($random(seed));
            end
        end
        $display("test packets done");
        wr(16'h04e0, 32'h0000_0000);
        cyc = 15'($random(seed));
        mt[7][26:12] = cyc;
        wr(16'h41ec, mt[7]);
        i_cycle_timer <= {5'h1f, cyc ^ 15'h4000, 12'hfff};
        fq.push_back({8'h80, p[31:4]});
        wr(16'h04e0, 32'h2000_8000);
        repeat (10) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        check("wait", o_ctx_active[7], 1'b0);
        @(posedge i_clk_sys);
        i_cycle_timer <= {5'h1f, cyc, 12'hfff};
        repeat (4) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        check("go", o_ctx_active[7], 1'b1);
        rd(16'h04e0, 32'h0000_8400);
        repeat (3) @(posedge i_clk_sys);
        $display("test start cycle done");
        close_out();
    end
    // whole run is well under 5000 cycles
    initial
    begin
        #2_000_000;
        failures++;
        close_out();
    end
endmodule
